// >>> hw/bsq_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

// =====================================================================
// Buck switch-mode sequencer, one channel
// =====================================================================
// Contract
// - Continuous mode: bottom switch on for all of each cycle's top-off time; the code leaves a one-clock dead gap before and after each top pulse.
// - Force-continuous low disables discontinuous and skip modes entirely.
// - Force-continuous high lets the channel enter discontinuous or skip freely.
// - Discontinuous: zero-current trip turns bottom off for rest of cycle.
// - After that trip both switches stay off until next cycle's top turn-on.
// - Zero current is evaluated only while the bottom switch is on.
// - Zero-current result is ignored for 50 ns after bottom turn-on.
// - Top switch stays on at least 10% of the period once turned on.
// - Output too high: both off, whole cycles skipped until back in range.
// - After skipping, resume discontinuous switching at the minimum top duty.
// - Shutdown holds both switches off, output left floating.
// - Leaving shutdown starts soft-start from the low duty limit.
// - Restart with force-continuous high runs discontinuous, blocking reverse current.
// - Duty ceiling reaches 90% after soft-start and is never exceeded.
module bsq_sequencer
    import bsq_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pins from outside the clock domain
    input wire logic run,
    input wire logic force_continuous_n,
    input wire bsq_sense_s sense,
    // Requested top on-time in clock cycles, from the loop logic
    input wire logic [CNT_W-1:0] duty_req,
    // Gate drive and status
    output bsq_gate_s gate,
    output bsq_mode_e mode,
    output logic ss_done
);

    // =================================================================
    // Input synchronisers
    // =================================================================
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic run_s;
    logic fcn_s;
    logic zc_s;
    logic hi_s;

    // Two flops per pin; only the second stage is read below
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
        end else begin
            sync_a <= {run, force_continuous_n, sense.zero_cross, sense.out_high};
            sync_b <= sync_a;
        end
    end

    assign run_s = sync_b[3];
    assign fcn_s = sync_b[2];
    assign zc_s = sync_b[1];
    assign hi_s = sync_b[0];

    // =================================================================
    // Cycle clock
    // =================================================================
    logic [CNT_W-1:0] phase;
    logic cycle_start;

    bsq_cycle_timer u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .enable(run_s),
        .phase(phase),
        .cycle_start(cycle_start)
    );

    // =================================================================
    // Soft-start duty ceiling
    // =================================================================
    logic [CNT_W-1:0] ss_limit;

    // Ceiling climbs one cycle count per switching cycle up to the cap
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run_s) begin
            ss_limit <= MIN_ON;
        end else if (cycle_start && ss_limit < MAX_ON) begin
            ss_limit <= ss_limit + CNT_ONE;
        end
    end

    // Status flag mirrors the ceiling having reached its cap
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ss_done <= 1'b0;
        end else begin
            ss_done <= run_s && (ss_limit == MAX_ON);
        end
    end

    // =================================================================
    // Per-cycle top on-time
    // =================================================================
    logic [CNT_W-1:0] top_len;
    logic skip_now;

    // Keeps the requested on-time between the floor and the ceiling
    function automatic logic [CNT_W-1:0] clamp_on(input logic [CNT_W-1:0] req,
                                                   input logic [CNT_W-1:0] lim);
        if (req < MIN_ON) begin
            clamp_on = MIN_ON;
        end else if (req > lim) begin
            clamp_on = lim;
        end else begin
            clamp_on = req;
        end
    endfunction

    // Skipping only allowed when force-continuous is released
    assign skip_now = fcn_s && hi_s;

    // Latched at the cycle start so a mid-cycle change cannot shorten a pulse
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run_s) begin
            top_len <= MIN_ON;
        end else if (cycle_start) begin
            if (mode == MODE_SKIP) begin
                top_len <= MIN_ON;
            end else begin
                top_len <= clamp_on(duty_req, ss_limit);
            end
        end
    end

    // =================================================================
    // Switching state machine
    // =================================================================
    bsq_state_e state;
    logic [CNT_W-1:0] cnt;

    // Cycle start has priority so each cycle begins on the cycle clock.
    // Top pulse tops out below the period, so it is never cut short.
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run_s) begin
            state <= ST_OFF;
            cnt <= CNT_ZERO;
        end else if (cycle_start) begin
            cnt <= CNT_ZERO;
            state <= skip_now ? ST_IDLE : ST_GAP_TOP;
        end else begin
            case (state)
                ST_OFF: begin
                    cnt <= CNT_ZERO;
                end
                ST_GAP_TOP: begin
                    cnt <= cnt + CNT_ONE;
                    if (cnt == DEAD_LAST) begin
                        state <= ST_TOP;
                        cnt <= CNT_ZERO;
                    end
                end
                ST_TOP: begin
                    cnt <= cnt + CNT_ONE;
                    if (cnt == top_len - CNT_ONE) begin
                        state <= ST_GAP_BOT;
                        cnt <= CNT_ZERO;
                    end
                end
                ST_GAP_BOT: begin
                    cnt <= cnt + CNT_ONE;
                    if (cnt == DEAD_LAST) begin
                        state <= ST_BOT;
                        cnt <= CNT_ZERO;
                    end
                end
                ST_BOT: begin
                    if (cnt != CNT_SAT) begin
                        cnt <= cnt + CNT_ONE;
                    end
                    // Ringing right after turn-on would trip the comparator early
                    if (fcn_s && zc_s && cnt >= BLANK) begin
                        state <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    cnt <= CNT_ZERO;
                end
                default: begin
                    state <= ST_OFF;
                    cnt <= CNT_ZERO;
                end
            endcase
        end
    end

    // Gates are a registered copy of the state: one-hot keeps them apart
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            gate <= '0;
        end else begin
            gate.top_switch <= (state == ST_TOP);
            gate.bottom_switch <= (state == ST_BOT);
        end
    end

    // =================================================================
    // Mode reporting
    // =================================================================
    logic zc_trip;

    // Trip seen this cycle; a trip on the start edge counts for the new cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run_s) begin
            zc_trip <= 1'b0;
        end else if (state == ST_BOT && fcn_s && zc_s && cnt >= BLANK) begin // Set beats clear
            zc_trip <= 1'b1;
        end else if (cycle_start) begin
            zc_trip <= 1'b0;
        end
    end

    // Mode set at each cycle start; the discontinuous report comes from a trip in the cycle just ended
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run_s) begin
            mode <= MODE_CONT;
        end else if (cycle_start) begin
            if (!fcn_s) begin
                mode <= MODE_CONT;
            end else if (hi_s) begin
                mode <= MODE_SKIP;
            end else if (zc_trip) begin
                mode <= MODE_DISC;
            end else begin
                mode <= MODE_CONT;
            end
        end
    end

    // =================================================================
    // Checks
    // =================================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic [CNT_W-1:0] top_run;

    // Length of the current top pulse, for the on-time checks
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !gate.top_switch) begin
            top_run <= CNT_ZERO;
        end else if (top_run != CNT_SAT) begin
            top_run <= top_run + CNT_ONE;
        end
    end

    a_no_overlap: assert property (!(gate.top_switch && gate.bottom_switch))
        else $error("top and bottom switches on together");
    a_gap_before_top: assert property ($rose(gate.top_switch) |-> !$past(gate.bottom_switch))
        else $error("top turned on with no gap after bottom");
    a_cont_bottom_hold: assert property (
        (state == ST_BOT && !fcn_s && run_s && !cycle_start) |=> state == ST_BOT)
        else $error("bottom left early in continuous mode");
    a_zc_blank_window: assert property (
        (state == ST_BOT && cnt < BLANK && run_s && !cycle_start) |=> state == ST_BOT)
        else $error("zero-current trip inside blanking window");
    a_zc_bottom_off: assert property (
        (state == ST_BOT && fcn_s && zc_s && cnt >= BLANK && run_s && !cycle_start)
        |=> state == ST_IDLE ##1 !gate.bottom_switch)
        else $error("bottom not turned off after zero current");
    a_idle_both_off: assert property (
        (state == ST_IDLE && !cycle_start) |=> (state == ST_IDLE || state == ST_OFF))
        else $error("switching resumed before cycle start");
    a_min_top_on: assert property (
        ($fell(gate.top_switch) && run_s && $past(run_s, 2)) |-> top_run >= MIN_ON)
        else $error("top on-time below minimum");
    a_max_top_on: assert property (top_run <= MAX_ON)
        else $error("top on-time above ceiling");
    a_skip_cycle: assert property (
        (cycle_start && run_s && fcn_s && hi_s) |=> state == ST_IDLE ##1 !gate.top_switch)
        else $error("cycle not skipped on high output");
    a_resume_min: assert property (
        (cycle_start && run_s && mode == MODE_SKIP) |=> top_len == MIN_ON)
        else $error("resume after skip not at minimum duty");
    a_shutdown_off: assert property (
        !run_s |-> ##2 (!gate.top_switch && !gate.bottom_switch))
        else $error("switch on during shutdown");
    a_soft_start_low: assert property (!run_s |=> ss_limit == MIN_ON)
        else $error("soft-start not reset to low limit");
    a_force_cont_mode: assert property (
        (cycle_start && run_s && !fcn_s) |=> mode == MODE_CONT && state == ST_GAP_TOP)
        else $error("force-continuous not honoured");
    a_cycle_start_top: assert property (
        (cycle_start && run_s && !skip_now) |=> state == ST_GAP_TOP ##1 state == ST_TOP)
        else $error("top not started at cycle start");

    c_disc_trip: cover property (state == ST_BOT ##1 state == ST_IDLE);
    c_skip_then_run: cover property (mode == MODE_SKIP ##[1:200] $rose(gate.top_switch));
    c_cont_cycle: cover property (state == ST_BOT && cycle_start && !fcn_s);
    c_soft_start_done: cover property ($rose(ss_done));

endmodule // bsq_sequencer

`default_nettype wire

// >>> hw/bsq_pkg.sv
// =====================================================================
// Shared constants and types for the buck switch-mode sequencer
// =====================================================================
package bsq_pkg;

    // =================================================================
    // Clock and switching rates
    // =================================================================
    localparam int CLK_FREQ_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SW_FREQ_HZ = 550_000;
    // Whole clock cycles per switching cycle, rounded down
    localparam int PERIOD_CYC = CLK_FREQ_HZ / SW_FREQ_HZ;

    // =================================================================
    // Timing figures in their own units
    // =================================================================
    localparam int MIN_ON_PCT = 10;
    localparam int MAX_DUTY_PCT = 90;
    localparam int BLANK_NS = 50;
    localparam int DEAD_NS = 25;

    // =================================================================
    // Derived cycle counts (least times round up, longest round down)
    // =================================================================
    localparam int MIN_ON_CYC = (PERIOD_CYC * MIN_ON_PCT + 99) / 100;
    localparam int MAX_ON_CYC = (PERIOD_CYC * MAX_DUTY_PCT) / 100;
    localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_RAW = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_CYC = (DEAD_RAW < 1) ? 1 : DEAD_RAW;

    // Counter width and the counts at that width
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYC - 1);
    localparam logic [CNT_W-1:0] MIN_ON = CNT_W'(MIN_ON_CYC);
    localparam logic [CNT_W-1:0] MAX_ON = CNT_W'(MAX_ON_CYC);
    localparam logic [CNT_W-1:0] BLANK = CNT_W'(BLANK_CYC);
    localparam logic [CNT_W-1:0] DEAD_LAST = CNT_W'(DEAD_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_SAT = 8'hFF;

    // =================================================================
    // Types
    // =================================================================
    // Gate drive pair toward the half-bridge
    typedef struct packed {
        logic top_switch;
        logic bottom_switch;
    } bsq_gate_s;

    // Comparator inputs from the analog side
    typedef struct packed {
        logic zero_cross;  // switch_node comparator, high at zero current
        logic out_high;    // output-rise sense
    } bsq_sense_s;

    // Conduction mode reported per switching cycle
    typedef enum logic [1:0] {
        MODE_CONT = 2'h0,
        MODE_DISC = 2'h1,
        MODE_SKIP = 2'h2
    } bsq_mode_e;

    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_GAP_TOP = 6'h02,
        ST_TOP = 6'h04,
        ST_GAP_BOT = 6'h08,
        ST_BOT = 6'h10,
        ST_IDLE = 6'h20
    } bsq_state_e;

endpackage

// >>> hw/bsq_cycle_timer.sv
`timescale 1ns/10ps
`default_nettype none

// =====================================================================
// Fixed-frequency switching-cycle timer
// =====================================================================
module bsq_cycle_timer
    import bsq_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control
    input wire logic enable,
    // Cycle position
    output logic [CNT_W-1:0] phase,
    output logic cycle_start
);

    // Parked at the last count while disabled, so the first cycle
    // starts on the edge right after enable rises
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !enable) begin
            phase <= PERIOD_LAST;
            cycle_start <= 1'b0;
        end else begin
            phase <= (phase == PERIOD_LAST) ? CNT_ZERO : phase + CNT_ONE;
            cycle_start <= (phase == PERIOD_LAST);
        end
    end

endmodule // bsq_cycle_timer

`default_nettype wire

// >>> tb/bsq_bridge_model.sv
`timescale 1ns/10ps
`default_nettype none

// =====================================================================
// Half-bridge and inductor seen from the gate pins
// =====================================================================
module bsq_bridge_model
    import bsq_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Gate drive and bench commands
    input wire bsq_gate_s gate,
    input wire logic [7:0] trip_after,
    input wire logic rise_cmd,
    // Comparator outputs
    output bsq_sense_s sense
);
    logic [7:0] on_cnt = 8'h00;
    logic last_top = 1'b1;
    logic noise = 1'b0;

    // Bottom-on time and which switch conducted last
    always @(posedge sys_clk) begin
        on_cnt <= gate.bottom_switch ? on_cnt + 8'h01 : 8'h00;
        noise <= ~noise;
        if (gate.top_switch) begin
            last_top <= 1'b1;
        end else if (gate.bottom_switch) begin
            last_top <= 1'b0;
        end
    end

    // A floating node gives no trustworthy comparator level, so it toggles
    always_comb begin
        if (gate.bottom_switch) begin
            sense.zero_cross = (trip_after != 8'h00) && (on_cnt >= trip_after);
        end else if (gate.top_switch || last_top) begin
            sense.zero_cross = 1'b0;  // Current still flowing forward
        end else begin
            sense.zero_cross = noise;
        end
        sense.out_high = rise_cmd;
    end
endmodule // bsq_bridge_model

`default_nettype wire

// >>> tb/bsq_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin failures++; \
    $display("Error at %0t ns: %s", $time, msg); end end

// =====================================================================
// Bench for one sequencer channel
// =====================================================================
module bsq_sequencer_tb
    import bsq_pkg::*;
;
    typedef struct {int top_w; int cut;} bsq_exp_s;
    logic sys_clk, rst_n, run, force_continuous_n, rise_cmd, ss_done;
    logic [7:0] duty_req, trip_after;
    bsq_sense_s sense;
    bsq_gate_s gate;
    bsq_gate_s prev = 2'h0;
    bsq_mode_e mode;
    bsq_exp_s exp_q[$];
    int failures = 0, comparisons = 0, falls = 0;
    int tw = 0, bw = 0, tw_last = 0, bw_last = 0, per = 0;
    logic per_ok = 1'b0;

    bsq_sequencer u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .run(run),
        .force_continuous_n(force_continuous_n), .sense(sense), .duty_req(duty_req),
        .gate(gate), .mode(mode), .ss_done(ss_done));
    bsq_bridge_model u_bridge (.sys_clk(sys_clk), .gate(gate), .trip_after(trip_after),
        .rise_cmd(rise_cmd), .sense(sense));

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    // Measure pulses on the falling edge, where registered gates have settled
    always @(negedge sys_clk) begin : monitor
        bsq_exp_s e;
        `CHK(gate.top_switch & (gate.bottom_switch | prev.bottom_switch), 1'b0, "top gap")
        `CHK(gate.bottom_switch & prev.top_switch, 1'b0, "bottom gap")
        per++;
        if (!run) per_ok = 1'b0;
        if (gate.top_switch && !prev.top_switch) begin
            if (per_ok) `CHK(per % 72, 0, "cycle spacing")
            per = 0;
            per_ok = 1'b1;
        end
        if (gate.top_switch) tw++;
        else if (tw != 0) begin
            tw_last = tw;
            tw = 0;
        end
        if (gate.bottom_switch) bw++;
        else if (bw != 0) begin
            bw_last = bw;
            bw = 0;
            falls++;
            if (exp_q.size() != 0) begin
                e = exp_q.pop_front();
                `CHK(tw_last, e.top_w, "top on-time")
                if (e.cut == 0) `CHK(bw_last, 70 - tw_last, "bottom fill")
                if (e.cut == 1) `CHK(bw_last < 70 - tw_last, 1'b1, "bottom stop")
            end
        end
        prev = gate;
    end

    // Bounded wait for bottom turn-offs so a stuck channel cannot hang the run
    task automatic wait_falls(input int n);
        int lim;
        lim = falls + n;
        for (int i = 0; i < 400 * n && falls < lim; i++) @(negedge sys_clk);
        `CHK(falls >= lim, 1'b1, "switching stalled")
    endtask

    // Duty is sampled at cycle start, so one whole cycle is let pass first
    task automatic cycles(input int n, input logic [7:0] duty, input int cut);
        bsq_exp_s e;
        wait_falls(1);
        duty_req = duty;
        wait_falls(1);
        e.top_w = duty < 8 ? 8 : (duty > 64 ? 64 : int'(duty));
        e.cut = cut;
        repeat (n) exp_q.push_back(e);
        wait_falls(n);
    endtask

    // Start in discontinuous mode against a reverse-current load
    task automatic restart(input string name);
        force_continuous_n = 1'b1;
        trip_after = 8'h14;
        duty_req = 8'h40;
        run = 1'b1;
        wait_falls(1);
        `CHK(tw_last >= 8 && tw_last <= 9, 1'b1, "soft-start width")
        `CHK(bw_last < 70 - tw_last, 1'b1, "restart pulls down")
        end_test(name);
    endtask

    // Per-test line
    task automatic end_test(input string name);
        $display("Test %s finished at %0t ns", name, $time);
    endtask

    // Counts and verdict
    task automatic finish_test();
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog well past the expected run of about 7000 clocks
    initial begin : watchdog
        repeat (40000) @(posedge sys_clk);
        failures++;
        $display("Error at %0t ns: watchdog expired", $time);
        finish_test();
    end

    // Main sequence; inputs move on the falling edge only
    initial begin : main
        logic [7:0] d;
        sys_clk = 1'b0;
        rst_n = 1'b0;
        run = 1'b0;
        force_continuous_n = 1'b1;
        rise_cmd = 1'b0;
        trip_after = 8'h00;
        duty_req = 8'h40;
        void'($urandom(70));
        repeat (12) @(negedge sys_clk);
        `CHK(gate, bsq_gate_s'(2'h0), "gates in reset")
        `CHK(mode, MODE_CONT, "mode in reset")
        `CHK(ss_done, 1'b0, "ceiling in reset")
        rst_n = 1'b1;
        repeat (20) @(negedge sys_clk);
        `CHK(gate, bsq_gate_s'(2'h0), "gates while run low")
        end_test("reset");
        restart("startup");
        for (int i = 0; i < 5000 && ss_done !== 1'b1; i++) @(negedge sys_clk);
        `CHK(ss_done, 1'b1, "soft-start done")
        // Continuous: boundaries of the clamp, then random duties
        force_continuous_n = 1'b0;
        for (int i = 0; i < 8; i++) begin
            d = i == 0 ? 8'h03 : i == 1 ? 8'h08 : i == 2 ? 8'hC8 : i == 3 ? 8'h40
                : 8'($urandom_range(64, 8));
            cycles(1, d, 0);
        end
        `CHK(mode, MODE_CONT, "mode continuous")
        rise_cmd = 1'b1;
        cycles(2, 8'h1E, 0);
        rise_cmd = 1'b0;
        end_test("continuous");
        // Discontinuous with a random trip point past the blanking
        force_continuous_n = 1'b1;
        trip_after = 8'($urandom_range(36, 16));
        cycles(3, 8'h14, 1);
        `CHK(mode, MODE_DISC, "mode discontinuous")
        end_test("discontinuous");
        // Skipping: whole cycles off, then a minimum-width pulse
        duty_req = 8'h28;
        rise_cmd = 1'b1;
        repeat (216) begin
            @(negedge sys_clk);
            `CHK(gate, bsq_gate_s'(2'h0), "gates during skip")
        end
        `CHK(mode, MODE_SKIP, "mode skip")
        rise_cmd = 1'b0;
        exp_q.push_back(bsq_exp_s'{8, 1});
        exp_q.push_back(bsq_exp_s'{40, 2});
        wait_falls(2);
        end_test("skip");
        // Shutdown mid-run, then a discontinuous restart
        run = 1'b0;
        repeat (4) @(negedge sys_clk);
        repeat (100) begin
            @(negedge sys_clk);
            `CHK(gate, bsq_gate_s'(2'h0), "gates in shutdown")
        end
        `CHK(ss_done, 1'b0, "ceiling dropped")
        end_test("shutdown");
        restart("restart");
        finish_test();
    end
endmodule // bsq_sequencer_tb

`default_nettype wire
